// ===== hdl/misc_msg_map.svh
`ifndef MISC_MSG_MAP_SVH
`define MISC_MSG_MAP_SVH

// Codes carried in the message kind field.
`define KIND_CREDITED 4'h1
`define KIND_UNCREDITED 4'h2
`define KIND_CREDIT_EXCH 4'h3
`define KIND_ERR_NOTICE 4'h4

// Trailer word codes and header bit positions within a 32-bit link word, byte k in bits [8k+7:8k].
`define TRAILER_KIND_ERR_POISON 3'h6
`define HDR_FLAG_BIT 7
`define HDR_KIND_LSB 3
`define HDR_LEN_HI_LSB 0
`define HDR_LEN_LO_LSB 14
`define HDR_CREDIT_LSB 12
`define HDR_OPCODE_LSB 8
`define HDR_PAY_LSB 16
`define TRL_KIND_LSB 4

// Payload size limits in bytes and the fixed size of a credit exchange body.
`define PAY_MIN_BYTES 6'h02
`define PAY_MAX_BYTES 6'h20
`define EXCH_BYTES 6'h06
`define EXCH_RSVD_LSB 16

// Misc credits held by the sender after reset, and the ceiling at which the count saturates.
`define INIT_MISC_CREDITS 8'h04
`define MAX_MISC_CREDITS 8'hff

`endif

// ===== hdl/misc_msg_pkg.sv
package misc_msg_pkg;

    typedef enum logic {TX_IDLE, TX_SEND} tx_phase_t;

    typedef enum logic [1:0] {RX_HEAD, RX_TRAIL, RX_PAY} rx_phase_t;

    typedef struct packed {
        tx_phase_t phase;
        logic req_ready;
        logic valid;
        logic last;
        logic [31:0] data;
        logic [3:0] idx;
        logic [3:0] nwords;
        logic [8:0][31:0] words;
        logic [7:0] credits;
    } tx_state_t;

    typedef struct packed {
        rx_phase_t phase;
        logic ready;
        logic [3:0] kind;
        logic [3:0] opcode;
        logic [1:0] credit;
        logic [4:0] len;
        logic [3:0] rem;
        logic [3:0] pos;
        logic [271:0] body;
        logic msg_valid;
        logic [3:0] msg_kind;
        logic [3:0] msg_opcode;
        logic [1:0] msg_credit;
        logic [5:0] msg_bytes;
        logic [255:0] msg_payload;
        logic credit_return_valid;
        logic [1:0] credit_return_count;
    } rx_state_t;

endpackage

// ===== hdl/misc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// One 32-bit word per accepted beat; last marks the final word of a message.
interface misc_link_if;
    logic valid;
    logic ready;
    logic [31:0] data;
    logic last;

    modport sender (
        output valid,
        output data,
        output last,
        input ready
    );

    modport receiver (
        input valid,
        input data,
        input last,
        output ready
    );
endinterface

`default_nettype wire

// ===== hdl/misc_msg_tx.sv
`include "misc_msg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module misc_msg_tx (
    input wire logic clk,
    input wire logic resetn,
    misc_link_if.sender link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [3:0] req_kind,
    input wire logic [3:0] req_opcode,
    input wire logic [1:0] req_credit,
    input wire logic [5:0] req_bytes,
    input wire logic [255:0] req_payload,
    input wire logic no_packing,
    input wire logic credit_return_valid,
    input wire logic [1:0] credit_return_count,
    output logic [7:0] misc_credits
);

    misc_msg_pkg::tx_state_t s;
    misc_msg_pkg::tx_state_t next_s;

    // Build scratch values, declared here so the process assigns them first.
    logic [5:0] nbytes;
    logic [4:0] len;
    logic [5:0] extra;

    // Header field values and the acceptance decision.
    logic [1:0] credit;
    logic pad;
    logic exch;
    logic needs_credit;
    logic take;

    // Payload and the two fixed words that are built before acceptance.
    logic [255:0] masked;
    logic [271:0] wide;
    logic [31:0] hdr_word;
    logic [31:0] pad_word;

    // Misc credit bookkeeping for this cycle.
    logic [1:0] returned;
    logic spent;
    logic [8:0] sum;

    // The whole message is built into word storage at acceptance, then streamed one word per beat.
    // Holding every word costs flops, but the streaming side becomes a plain index walk.
    always_comb begin
        // Defaults hold the state and give every scratch value a known start.
        next_s = s;
        nbytes = req_bytes;
        len = 5'h00;
        extra = 6'h00;
        credit = req_credit;
        pad = 1'b0;
        exch = (req_kind == `KIND_CREDIT_EXCH);
        needs_credit = (req_kind == `KIND_CREDITED);
        take = 1'b0;
        masked = req_payload;
        wide = 272'h0;
        hdr_word = 32'h0000_0000;
        pad_word = 32'h0000_0000;
        returned = 2'b00;
        spent = 1'b0;
        sum = 9'h000;

        // Out-of-range sizes are clamped rather than refused, so the link never sees an illegal length.
        if (nbytes < `PAY_MIN_BYTES) begin
            nbytes = `PAY_MIN_BYTES;
        end else if (nbytes > `PAY_MAX_BYTES) begin
            nbytes = `PAY_MAX_BYTES;
        end

        // A credit exchange has a fixed size; its piggyback field and reserved bytes 2 and 3 stay zero.
        if (exch) begin
            nbytes = `EXCH_BYTES;
            credit = 2'b00;
            masked[`EXCH_RSVD_LSB +: 16] = 16'h0000;
        end

        // Bytes past the payload are reserved and sent as zero.
        for (int b = 0; b < 32; b++) begin
            if (b >= int'(nbytes)) begin
                masked[8*b +: 8] = 8'h00;
            end
        end

        // The length field counts payload bytes less one; each word after the header carries four more.
        len = 5'(nbytes - 6'h01);
        extra = (6'(len) + 6'h02) >> 2;

        // With packing off a lone header word is below the transport's minimum, so a trailer pads it.
        pad = no_packing && (extra == 6'h00);

        // Payload shifted by the two bytes that ride in the header, so word j starts at byte 4j-2.
        wide = {16'h0000, masked};

        // Header word: byte 0 flag, kind, length high; byte 1 length low, credit, opcode.
        // Bytes 2 and 3 carry the first two payload bytes.
        hdr_word[`HDR_FLAG_BIT] = pad;
        hdr_word[`HDR_KIND_LSB +: 4] = req_kind;
        hdr_word[`HDR_LEN_HI_LSB +: 3] = len[4:2];
        hdr_word[`HDR_LEN_LO_LSB +: 2] = len[1:0];
        hdr_word[`HDR_CREDIT_LSB +: 2] = credit;
        hdr_word[`HDR_OPCODE_LSB +: 4] = req_opcode;
        hdr_word[`HDR_PAY_LSB +: 16] = masked[15:0];

        // The pad trailer holds its kind code alone: zero error code, zero corruption marks, no chain bit.
        pad_word[`TRL_KIND_LSB +: 3] = `TRAILER_KIND_ERR_POISON;

        // Accept a request when idle, then walk the stored words while the receiver takes them.
        unique case (s.phase)
            misc_msg_pkg::TX_IDLE: begin
                // A credited message needs a misc credit in hand.
                // Without one the request simply waits; nothing else signals the refusal.
                take = req_valid && s.req_ready && !(needs_credit && (s.credits == 8'h00));
                if (take) begin
                    // Payload words follow the header; the pad trailer takes word 1 when it is present.
                    next_s.words[0] = hdr_word;
                    for (int j = 1; j < 9; j++) begin
                        next_s.words[j] = wide[32*j-16 +: 32];
                    end
                    if (pad) begin
                        next_s.words[1] = pad_word;
                    end

                    // The first beat goes out next cycle; the request side stays closed until the last word.
                    next_s.nwords = 4'(extra) + 4'h1 + {3'b000, pad};
                    next_s.idx = 4'h0;
                    next_s.data = next_s.words[0];
                    next_s.valid = 1'b1;
                    next_s.last = (next_s.nwords == 4'h1);
                    next_s.req_ready = 1'b0;
                    next_s.phase = misc_msg_pkg::TX_SEND;
                end
            end
            misc_msg_pkg::TX_SEND: begin
                // Each accepted word moves the index on; acceptance of the last word closes the message.
                if (s.valid && link.ready) begin
                    if (s.last) begin
                        // Ready returns only after the last word, so one message is in flight at a time.
                        next_s.valid = 1'b0;
                        next_s.last = 1'b0;
                        next_s.req_ready = 1'b1;
                        next_s.phase = misc_msg_pkg::TX_IDLE;
                    end else begin
                        // Data and last change only on an accepted beat, so both hold while the far end stalls.
                        next_s.idx = s.idx + 4'h1;
                        next_s.data = s.words[s.idx + 4'h1];
                        next_s.last = ((s.idx + 4'h2) == s.nwords);
                    end
                end
            end
        endcase

        // A credit returned in the same cycle as one is spent is kept; the count saturates at the top.
        // Saturation only guards a misbehaving peer, as a sane peer never returns more than it was given.
        returned = credit_return_valid ? credit_return_count : 2'b00;
        spent = take && needs_credit;
        sum = {1'b0, s.credits} + {7'h00, returned};
        sum = sum - {8'h00, spent};
        next_s.credits = (sum > {1'b0, `MAX_MISC_CREDITS}) ? `MAX_MISC_CREDITS : sum[7:0];
    end

    // All state updates here; reset leaves the sender idle and ready.
    // Only constants are loaded in reset, so nothing from the logic reaches the asynchronous path.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.phase <= misc_msg_pkg::TX_IDLE;
            s.req_ready <= 1'b1;
            // The sender starts with its initial misc credit allowance.
            s.credits <= `INIT_MISC_CREDITS;
        end else begin
            s <= next_s;
        end
    end

    // Link outputs are flops of the state, so the far end never sees a combinational path.
    assign link.valid = s.valid;
    assign link.data = s.data;
    assign link.last = s.last;

    // Request-side outputs come straight from flops as well.
    assign req_ready = s.req_ready;
    assign misc_credits = s.credits;

endmodule

`default_nettype wire

// ===== hdl/misc_msg_rx.sv
`include "misc_msg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module misc_msg_rx (
    input wire logic clk,
    input wire logic resetn,
    misc_link_if.receiver link,
    output logic msg_valid,
    output logic [3:0] msg_kind,
    output logic [3:0] msg_opcode,
    output logic [1:0] msg_credit,
    output logic [5:0] msg_bytes,
    output logic [255:0] msg_payload,
    output logic credit_return_valid,
    output logic [1:0] credit_return_count
);

    misc_msg_pkg::rx_state_t s;
    misc_msg_pkg::rx_state_t next_s;

    logic [31:0] d;
    logic done;
    logic [4:0] len;
    logic [5:0] nbytes;

    // One word is taken every cycle; the length field, the header flag and the trailer chain bits decide where a message ends.
    always_comb begin
        next_s = s;
        d = link.data;
        done = 1'b0;
        len = s.len;
        nbytes = 6'h00;
        next_s.msg_valid = 1'b0;
        next_s.credit_return_valid = 1'b0;

        if (link.valid && s.ready) begin
            unique case (s.phase)
                misc_msg_pkg::RX_HEAD: begin
                    len = {d[`HDR_LEN_HI_LSB +: 3], d[`HDR_LEN_LO_LSB +: 2]};
                    next_s.len = len;
                    next_s.kind = d[`HDR_KIND_LSB +: 4];
                    next_s.opcode = d[`HDR_OPCODE_LSB +: 4];
                    next_s.credit = d[`HDR_CREDIT_LSB +: 2];
                    next_s.body = {256'h0, d[`HDR_PAY_LSB +: 16]};
                    next_s.rem = 4'((6'(len) + 6'h02) >> 2);
                    next_s.pos = 4'h1;
                    if (d[`HDR_FLAG_BIT]) begin
                        next_s.phase = misc_msg_pkg::RX_TRAIL;
                    end else if (next_s.rem == 4'h0) begin
                        done = 1'b1;
                    end else begin
                        next_s.phase = misc_msg_pkg::RX_PAY;
                    end
                end
                misc_msg_pkg::RX_TRAIL: begin
                    // Trailer words are discarded whatever their kind; only the chain bit matters.
                    if (!d[`HDR_FLAG_BIT]) begin
                        if (s.rem == 4'h0) begin
                            done = 1'b1;
                        end else begin
                            next_s.phase = misc_msg_pkg::RX_PAY;
                        end
                    end
                end
                misc_msg_pkg::RX_PAY: begin
                    next_s.body[32*int'(s.pos)-16 +: 32] = d;
                    next_s.pos = s.pos + 4'h1;
                    next_s.rem = s.rem - 4'h1;
                    if (s.rem == 4'h1) begin
                        done = 1'b1;
                    end
                end
                default: begin
                    next_s.phase = misc_msg_pkg::RX_HEAD;
                end
            endcase
        end

        if (done) begin
            nbytes = 6'(len) + 6'h01;
            next_s.phase = misc_msg_pkg::RX_HEAD;
            next_s.msg_valid = 1'b1;
            next_s.msg_kind = next_s.kind;
            next_s.msg_opcode = next_s.opcode;
            next_s.msg_credit = next_s.credit;
            next_s.msg_bytes = nbytes;
            next_s.msg_payload = next_s.body[255:0];
            // Reserved bytes after the payload are dropped here.
            for (int b = 0; b < 32; b++) begin
                if (b >= int'(nbytes)) begin
                    next_s.msg_payload[8*b +: 8] = 8'h00;
                end
            end
            // Credits piggybacked on any message except a credit exchange are handed back.
            if ((next_s.kind != `KIND_CREDIT_EXCH) && (next_s.credit != 2'b00)) begin
                next_s.credit_return_valid = 1'b1;
                next_s.credit_return_count = next_s.credit;
            end
        end
    end

    // All state updates here; ready rises at the first edge after reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.phase <= misc_msg_pkg::RX_HEAD;
        end else begin
            s <= next_s;
            s.ready <= 1'b1;
        end
    end

    assign link.ready = s.ready;
    assign msg_valid = s.msg_valid;
    assign msg_kind = s.msg_kind;
    assign msg_opcode = s.msg_opcode;
    assign msg_credit = s.msg_credit;
    assign msg_bytes = s.msg_bytes;
    assign msg_payload = s.msg_payload;
    assign credit_return_valid = s.credit_return_valid;
    assign credit_return_count = s.credit_return_count;

endmodule

`default_nettype wire

// ===== sim/misc_link_chk.sv
`timescale 1ns/1ps
`default_nettype none

module misc_link_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic valid,
    input wire logic ready,
    input wire logic [31:0] data,
    input wire logic last
);
    logic in_msg;
    logic [3:0] rem;
    logic [4:0] hlen;
    logic acc;
    logic first;
    logic [4:0] len;

    // Header fields are decoded straight from the wire word.
    assign acc = valid && ready;
    assign first = !in_msg;
    assign len = {data[2:0], data[15:14]};

    // Words still owed after the header, so the end is judged from the length field and the pad flag.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_msg <= 1'b0;
            rem <= 4'h0;
            hlen <= 5'h00;
        end else if (acc) begin
            in_msg <= !last;
            if (first) begin
                rem <= 4'((6'(len) + 6'h02) >> 2) + 4'(data[7]);
                hlen <= len;
            end else begin
                rem <= rem - 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_KIND_LEGAL: assert property (acc && first |-> data[6:3] inside {4'h1, 4'h2, 4'h3, 4'h4})
        else $error("header kind out of range");
    AST_LEN_MIN: assert property (acc && first |-> len != 5'h00)
        else $error("payload shorter than two bytes");
    AST_NO_EXCH_CREDIT: assert property (acc && first && data[6:3] == 4'h3 |-> data[13:12] == 2'h0)
        else $error("credit exchange carries credits");
    AST_PAD_WORD: assert property (acc && first && data[7] |=> valid && data == 32'h0000_0060)
        else $error("pad trailer word not clean");
    AST_TRL_KIND: assert property (acc && first && data[7] |=> data[6:4] == 3'h6)
        else $error("trailer kind wrong");
    AST_HDR_END: assert property (acc && first |-> last == (len < 5'h02 && !data[7]))
        else $error("header last flag disagrees with length");
    AST_WORD_END: assert property (acc && !first |-> last == (rem == 4'h1))
        else $error("message end disagrees with length");
    AST_SPARE_ZERO: assert property (acc && !first && rem == 4'h1 && hlen[1:0] != 2'h1
        |-> (data >> {2'(hlen[1:0] - 2'h1), 3'h0}) == 32'h0000_0000)
        else $error("spare bytes not zero");

    cover property (acc && first && data[7]);
    cover property (acc && first && data[6:3] == 4'h3);
    cover property (acc && first && len == 5'h1f);
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk = 0;
    logic resetn = 0;
    logic req_valid = 0;
    logic [3:0] req_kind = 0;
    logic [3:0] req_opcode = 0;
    logic [1:0] req_credit = 0;
    logic [5:0] req_bytes = 0;
    logic [255:0] req_payload = 0;
    logic no_packing = 0;
    logic req_ready, msg_valid, crv, mid;
    logic [3:0] msg_kind, msg_opcode;
    logic [1:0] msg_credit, crc;
    logic [5:0] msg_bytes;
    logic [255:0] msg_payload;
    logic [7:0] misc_credits;
    logic [31:0] hdr;
    int err_count = 0;
    int num_checks = 0;
    int exp_cred = 4;

    always #2 clk = ~clk;

    misc_link_if misc_link_if_i ();
    misc_msg_tx misc_msg_tx_i (.clk(clk), .resetn(resetn), .link(misc_link_if_i.sender), .req_valid(req_valid),
        .req_ready(req_ready), .req_kind(req_kind), .req_opcode(req_opcode), .req_credit(req_credit),
        .req_bytes(req_bytes), .req_payload(req_payload), .no_packing(no_packing),
        .credit_return_valid(crv), .credit_return_count(crc), .misc_credits(misc_credits));
    misc_msg_rx misc_msg_rx_i (.clk(clk), .resetn(resetn), .link(misc_link_if_i.receiver),
        .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_opcode(msg_opcode), .msg_credit(msg_credit),
        .msg_bytes(msg_bytes), .msg_payload(msg_payload), .credit_return_valid(crv), .credit_return_count(crc));
    misc_link_chk misc_link_chk_i (.clk(clk), .resetn(resetn), .valid(misc_link_if_i.valid),
        .ready(misc_link_if_i.ready), .data(misc_link_if_i.data), .last(misc_link_if_i.last));

    // Keep the header word of each message as it crosses the wire.
    always @(posedge clk) begin
        if (!resetn) begin
            mid <= 1'b0;
        end else if (misc_link_if_i.valid && misc_link_if_i.ready) begin
            if (!mid) hdr <= misc_link_if_i.data;
            mid <= !misc_link_if_i.last;
        end
    end

    task automatic check(input string name, input logic [255:0] exp, input logic [255:0] got);
        num_checks++;
        if (exp !== got) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One message end to end; the receiver's view is compared with what was asked for.
    task automatic send(input logic [3:0] k, input logic [3:0] op, input logic [1:0] cr, input logic [5:0] nb,
        input logic np);
        logic [255:0] exp;
        logic [5:0] eb;
        logic [1:0] ec;
        int n;
        eb = (k == 4'h3) ? 6'h06 : (nb < 6'h02) ? 6'h02 : (nb > 6'h20) ? 6'h20 : nb;
        ec = (k == 4'h3) ? 2'h0 : cr;
        exp = '0;
        for (int b = 0; b < 32; b++) req_payload[8*b +: 8] = 8'(b * 3 + op * 17 + 1);
        for (int b = 0; b < 32; b++) if (b < eb) exp[8*b +: 8] = req_payload[8*b +: 8];
        if (k == 4'h3) exp[31:16] = 16'h0000;
        req_kind = k;
        req_opcode = op;
        req_credit = cr;
        req_bytes = nb;
        no_packing = np;
        req_valid = 1;
        n = 0;
        while (!req_ready && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1 req_valid = 0;
        n = 0;
        while (!msg_valid && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        if (!msg_valid) begin
            err_count++;
            $display("[FAIL] msg_valid expected 1 seen 0");
            conclude();
        end
        check("kind", k, msg_kind);
        check("opcode", op, msg_opcode);
        check("credit", ec, msg_credit);
        check("bytes", eb, msg_bytes);
        check("payload", exp, msg_payload);
        check("return", ec != 2'h0, crv);
        if (ec != 2'h0) check("return count", ec, crc);
        check("pad flag", np && eb == 6'h02, hdr[7]);
        check("hdr credit", ec, hdr[13:12]);
        exp_cred = exp_cred - (k == 4'h1) + ec;
        @(posedge clk);
        #1 check("credits", exp_cred, misc_credits);
    endtask

    initial begin
        int n;
        repeat (16) @(posedge clk);
        #1 resetn = 1;
        check("credits", 8'h04, misc_credits);
        check("ready", 1'b1, req_ready);
        send(4'h1, 4'h5, 2'h0, 6'h02, 1'b1);
        send(4'h2, 4'ha, 2'h3, 6'h20, 1'b0);
        send(4'h3, 4'h0, 2'h2, 6'h06, 1'b0);
        send(4'h4, 4'h4, 2'h1, 6'h1f, 1'b0);
        send(4'h1, 4'hf, 2'h2, 6'h07, 1'b1);
        send(4'h2, 4'h3, 2'h0, 6'h02, 1'b0);
        send(4'h2, 4'h6, 2'h0, 6'h3f, 1'b0);
        send(4'h2, 4'h7, 2'h0, 6'h00, 1'b1);
        for (int i = 0; i < 8; i++) send(4'h1, 4'(i), 2'h0, 6'(3 + 4 * i), 1'b1);
        // With no misc credit left a credited request must sit untaken.
        req_kind = 4'h1;
        req_valid = 1;
        n = 0;
        repeat (10) begin
            @(posedge clk);
            #1 n += msg_valid;
        end
        check("refused ready", 1'b1, req_ready);
        check("refused msgs", 0, n);
        req_valid = 0;
        @(posedge clk);
        #1 send(4'h4, 4'h2, 2'h3, 6'h20, 1'b0);
        send(4'h1, 4'h9, 2'h1, 6'h02, 1'b0);
        conclude();
    end
endmodule

`default_nettype wire
